// ---- rtl/shift_stage_pkg.sv ----
package shift_stage_pkg;

  // number of storage locations in the chain
  localparam int unsigned STAGE_COUNT = 4;

  // reset value of every location and of the edge bookkeeping
  localparam logic [3:0] STAGES_RESET = 4'h0;
  localparam logic       BIT_RESET    = 1'h0;

  // field positions inside the stage vector
  localparam int unsigned POS_STAGE_ONE   = 0;
  localparam int unsigned POS_STAGE_TWO   = 1;
  localparam int unsigned POS_STAGE_THREE = 2;
  localparam int unsigned POS_STAGE_FOUR  = 3;

  // synchroniser depth for field inputs
  localparam int unsigned SYNC_STAGES = 2;

endpackage : shift_stage_pkg

// ---- rtl/four_stage_shift_register.sv ----
// What this block does
// RL1 - rising-edge pulse output is high one cycle when input first seen on
// RL2 - falling-edge pulse output is high one cycle when input first seen off
// RL3 - shift strobe lasts exactly one cycle per off-to-on shift input edge
// RL4 - first cycle with shift on and edge memory off sets strobe and memory
// RL5 - coil results become visible to contacts only after the cycle ends
// RL6 - next cycle sees edge memory on, drops strobe, strobe updates stages once
// RL7 - no new strobe until shift input returns off
// RL8 - strobe loads stage one from the value input
// RL9 - stages update last to first, each taking its predecessor's old content
// RL10 - rungs evaluate top to bottom, each coil from its own rung
// RL11 - stages hold their state through every cycle without a strobe or a clear
// RL12 - clear input held on forces all four stages off
// RL13 - clear beats a coincident strobe; stages end the cycle off
// RL14 - data moves only from stage one toward stage four, four bits total
// RL15 - true and inverted state of each stage are provided
// RL16 - user should encode reject as zero so an accidental clear rejects all
// RL17 - stages, edge memory, strobe and pulse outputs start off
module four_stage_shift_register #(
  parameter int unsigned STAGES = shift_stage_pkg::STAGE_COUNT
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       shift_pulse_in_i,
  input  wire logic       value_in_i,
  input  wire logic       clear_in_i,
  output logic [3:0]      stages_o,
  output logic [3:0]      stages_n_o,
  output logic            shift_strobe_o,
  output logic            pulse_out_rise_o,
  output logic            pulse_out_fall_o
);

  // field pins are asynchronous to the scan clock
  logic [2:0] sync1_q;
  logic [2:0] sync1_d;
  logic [2:0] sync2_q;
  logic [2:0] sync2_d;

  // coil state; the registers are the contacts read in the next scan
  logic [3:0] stages_q;
  logic [3:0] stages_d;
  logic       edge_memory_q;
  logic       edge_memory_d;
  logic       shift_strobe_q;
  logic       shift_strobe_d;
  logic       shift_prev_q;
  logic       shift_prev_d;
  logic       rise_q;
  logic       rise_d;
  logic       fall_q;
  logic       fall_d;
  logic [3:0] stages_n_q;
  logic [3:0] stages_n_d;

  logic shift_s;
  logic value_s;
  logic clear_s;

  // the rungs are written out for exactly four locations, so any other depth is refused
  if (STAGES != shift_stage_pkg::STAGE_COUNT)
  begin : g_bad_depth
    $error("stage count must be four");
  end

  // synchroniser next values: second stage reads only the first
  always_comb
  begin
    sync1_d = {clear_in_i, value_in_i, shift_pulse_in_i};
    sync2_d = sync1_q;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign shift_s = sync2_q[0];
  assign value_s = sync2_q[1];
  assign clear_s = sync2_q[2];

  // index helper so every destination field position comes from the package
  function automatic int unsigned package_pos(input int unsigned p);
    package_pos = p;
  endfunction : package_pos

  // one scan: rungs in program order, contacts read last cycle's coils
  always_comb
  begin
    // RL10: top rung first, the strobe rung sees the old edge memory
    shift_strobe_d = shift_s & ~edge_memory_q; // RL4 RL3 RL7
    edge_memory_d  = shift_s;                  // RL4 RL7
    // edge detectors on the pulse generator rungs
    rise_d = shift_s & ~shift_prev_q;          // RL1
    fall_d = ~shift_s & shift_prev_q;          // RL2
    shift_prev_d = shift_s;
    // storage rungs use the strobe contact, i.e. last cycle's coil
    stages_d = stages_q;                       // RL11
    if (shift_strobe_q)                        // RL6 RL5
    begin
      // old values shift up; reading registered stages models last-to-first
      stages_d[package_pos(shift_stage_pkg::POS_STAGE_FOUR)]  = stages_q[2]; // RL9 RL14
      stages_d[package_pos(shift_stage_pkg::POS_STAGE_THREE)] = stages_q[1]; // RL9
      stages_d[package_pos(shift_stage_pkg::POS_STAGE_TWO)]   = stages_q[0]; // RL9
      stages_d[package_pos(shift_stage_pkg::POS_STAGE_ONE)]   = value_s;     // RL8
    end
    // clear rung sits last so it overrides the set path
    if (clear_s)
    begin
      stages_d = shift_stage_pkg::STAGES_RESET; // RL12 RL13
    end
    stages_n_d = ~stages_d;                      // RL15
  end

  // coil states transferred to contacts at end of scan
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      stages_q       <= shift_stage_pkg::STAGES_RESET; // RL17
      stages_n_q     <= ~shift_stage_pkg::STAGES_RESET;
      edge_memory_q  <= shift_stage_pkg::BIT_RESET;
      shift_strobe_q <= shift_stage_pkg::BIT_RESET;
      shift_prev_q   <= shift_stage_pkg::BIT_RESET;
      rise_q         <= shift_stage_pkg::BIT_RESET;
      fall_q         <= shift_stage_pkg::BIT_RESET;
    end
    else
    begin
      stages_q       <= stages_d;      // RL5
      stages_n_q     <= stages_n_d;
      edge_memory_q  <= edge_memory_d;
      shift_strobe_q <= shift_strobe_d;
      shift_prev_q   <= shift_prev_d;
      rise_q         <= rise_d;
      fall_q         <= fall_d;
    end
  end

  assign stages_o         = stages_q;
  assign stages_n_o       = stages_n_q;
  assign shift_strobe_o   = shift_strobe_q;
  assign pulse_out_rise_o = rise_q;
  assign pulse_out_fall_o = fall_q;

  // strobe follows a new rising edge of the synchronised shift input
  sequence s_shift_edge;
    shift_s && !edge_memory_q;
  endsequence

  property p_strobe_on_edge;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_shift_edge |=> shift_strobe_q && edge_memory_q;
  endproperty
  a_strobe_on_edge: assert property (p_strobe_on_edge) else $error("strobe missed edge"); // RL4

  property p_strobe_one_cycle;
    @(posedge clock_i) disable iff (sys_rst_i)
      shift_strobe_q |=> !shift_strobe_q;
  endproperty
  a_strobe_one_cycle: assert property (p_strobe_one_cycle) else $error("strobe too long"); // RL3

  property p_no_restrobe;
    @(posedge clock_i) disable iff (sys_rst_i)
      shift_strobe_q ##1 (shift_s && $past(shift_s)) |=> !shift_strobe_q;
  endproperty
  a_no_restrobe: assert property (p_no_restrobe) else $error("strobe repeated"); // RL7

  property p_rise_pulse;
    @(posedge clock_i) disable iff (sys_rst_i)
      (shift_s && !shift_prev_q) |=> rise_q ##1 !rise_q;
  endproperty
  a_rise_pulse: assert property (p_rise_pulse) else $error("rise pulse wrong"); // RL1

  property p_fall_pulse;
    @(posedge clock_i) disable iff (sys_rst_i)
      (!shift_s && shift_prev_q) |=> fall_q ##1 !fall_q;
  endproperty
  a_fall_pulse: assert property (p_fall_pulse) else $error("fall pulse wrong"); // RL2

  property p_shift_data;
    @(posedge clock_i) disable iff (sys_rst_i)
      (shift_strobe_q && !clear_s) |=> stages_q == {$past(stages_q[2:0]), $past(value_s)};
  endproperty
  a_shift_data: assert property (p_shift_data) else $error("shift data wrong"); // RL9

  property p_clear_wins;
    @(posedge clock_i) disable iff (sys_rst_i)
      clear_s |=> stages_q == 4'h0;
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("clear lost"); // RL13

  property p_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
      (!shift_strobe_q && !clear_s) |=> $stable(stages_q);
  endproperty
  a_hold: assert property (p_hold) else $error("stage changed without strobe"); // RL11

  property p_inverted;
    @(posedge clock_i) disable iff (sys_rst_i)
      stages_n_q == ~stages_q;
  endproperty
  a_inverted: assert property (p_inverted) else $error("inverted copy wrong"); // RL15

  // stage one takes the value input on every strobe that clear does not override
  property p_load_one;
    @(posedge clock_i) disable iff (sys_rst_i)
      (shift_strobe_q && !clear_s) |=> stages_q[shift_stage_pkg::POS_STAGE_ONE] == $past(value_s);
  endproperty
  a_load_one: assert property (p_load_one) else $error("stage one not loaded"); // RL8

  // edge memory stays on while the shift input stays on, blocking a new strobe
  property p_memory_tracks;
    @(posedge clock_i) disable iff (sys_rst_i)
      shift_s |=> edge_memory_q;
  endproperty
  a_memory_tracks: assert property (p_memory_tracks) else $error("edge memory dropped"); // RL7

  // reset leaves stages, strobe, pulses and edge memory off; checked without disable so reset itself is watched
  property p_reset_state;
    @(posedge clock_i)
      sys_rst_i |=> (stages_q == shift_stage_pkg::STAGES_RESET) && !shift_strobe_q && !rise_q && !fall_q
        && !edge_memory_q;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong"); // RL17

endmodule : four_stage_shift_register

// ---- verification/field_inputs.sv ----
// pushbuttons and sensors on the shift, value and clear pins
module field_inputs (
  input  wire logic clock_i,
  output logic      shift_pulse_in_o,
  output logic      value_in_o,
  output logic      clear_in_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // contacts start open so the block sees nothing during reset
  initial
  begin
    shift_pulse_in_o = 1'h0;
    value_in_o       = 1'h0;
    clear_in_o       = 1'h0;
  end

  // contacts move just after an edge; the pins are synchronised inside
  task automatic drive(input logic s, input logic v, input logic c);
    @(posedge clock_i);
    #10;
    shift_pulse_in_o = s;
    value_in_o       = v;
    clear_in_o       = c;
  endtask : drive
endmodule : field_inputs

// ---- verification/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i   = 1'h0;
  logic       sys_rst_i = 1'h1;
  logic       shift_w, value_w, clear_w, strobe, rise, fall;
  logic [3:0] stages, stages_n;
  logic [3:0] exp_q     = 4'h0;
  int         err_count = 0;
  int         n_checks  = 0;

  always #50 clock_i = ~clock_i;

  field_inputs u_field_inputs (.clock_i(clock_i), .shift_pulse_in_o(shift_w), .value_in_o(value_w),
    .clear_in_o(clear_w));
  four_stage_shift_register u_four_stage_shift_register (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .shift_pulse_in_i(shift_w), .value_in_i(value_w), .clear_in_i(clear_w), .stages_o(stages),
    .stages_n_o(stages_n), .shift_strobe_o(strobe), .pulse_out_rise_o(rise), .pulse_out_fall_o(fall));

  task automatic chk(input logic [3:0] got, input logic [3:0] want, input string what);
    n_checks++;
    if (got !== want)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // sample 10 ns after the rising edge so edge updates have landed
  task automatic tick();
    @(posedge clock_i);
    #10;
  endtask : tick

  // bounded wait for the strobe (sel 0) or the falling pulse (sel 1)
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    do
    begin
      tick();
      n++;
    end while ((sel ? fall : strobe) !== 1'h1 && n < 10);
    if ((sel ? fall : strobe) !== 1'h1)
    begin
      err_count++;
      $display("[ERR] %0t pulse never came", $time);
      give_verdict();
    end
  endtask : wait_hi

  // one press with a held button, then release
  task automatic t_shift(input logic v);
    u_field_inputs.drive(1'h1, v, 1'h0);
    wait_hi(0);
    chk({3'h0, rise}, 4'h1, "rise with strobe");
    exp_q = {exp_q[2:0], v};
    tick();
    chk({2'h0, strobe, rise}, 4'h0, "one cycle only");
    chk(stages, exp_q, "stages");
    chk(stages_n, ~exp_q, "inverse");
    // button stays down: no second strobe, contents hold
    repeat (6)
    begin
      tick();
      chk({3'h0, strobe}, 4'h0, "held button");
      chk(stages, exp_q, "hold");
    end
    u_field_inputs.drive(1'h0, v, 1'h0);
    wait_hi(1);
    chk({3'h0, strobe}, 4'h0, "no strobe on release");
    tick();
    chk({3'h0, fall}, 4'h0, "fall one cycle");
  endtask : t_shift

  // clear alone, then clear racing a strobe
  task automatic t_clear();
    u_field_inputs.drive(1'h0, 1'h1, 1'h1);
    repeat (3) tick();
    chk(stages, 4'h0, "clear");
    chk(stages_n, 4'hF, "clear inverse");
    exp_q = 4'h0;
    u_field_inputs.drive(1'h0, 1'h1, 1'h0);
    t_shift(1'h1);
    u_field_inputs.drive(1'h1, 1'h1, 1'h1);
    wait_hi(0);
    tick();
    chk(stages, 4'h0, "clear beats strobe");
    exp_q = 4'h0;
    u_field_inputs.drive(1'h0, 1'h0, 1'h0);
    repeat (4) tick();
  endtask : t_clear

  initial
  begin
    repeat (5) tick();
    chk({strobe, rise, fall, 1'h0}, 4'h0, "reset flags");
    chk(stages_n, 4'hF, "reset inverse");
    sys_rst_i = 1'h0;
    repeat (3) tick();
    chk(stages, 4'h0, "start empty");
    // value pattern 1,0,0,1,0 walks data from stage one to four
    t_shift(1'h1);
    t_shift(1'h0);
    t_shift(1'h0);
    t_shift(1'h1);
    t_shift(1'h0);
    t_clear();
    give_verdict();
  end
endmodule : tb_top
